// ==== logic/wdog_pkg.sv ====
// Constants for the watchdog timeout guard
// What this block does
// - Software programs the timeout in whole seconds.
// - Writing the timeout does not start counting; a start command does.
// - Debug mode expiry raises an interrupt, no reset.
// - Debug mode counts exactly like reboot mode; only expiry action differs.
// - Reboot mode expiry asserts a whole-chip reset.
// - Each service while running reloads the full timeout interval; a service while stopped does nothing.
package wdog_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] TIMEOUT_OFS   = 8'h00;
  localparam logic [7:0] CMD_OFS       = 8'h04;
  localparam logic [7:0] REMAIN_S_OFS  = 8'h08;
  localparam logic [7:0] REMAIN_T_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS    = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS    = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFS   = 8'h1C;
  // ------------------------------------------------------------
  // Command codes and fields
  // ------------------------------------------------------------
  localparam logic [1:0] CMD_STOP      = 2'h0;
  localparam logic [1:0] CMD_DEBUG     = 2'h1;
  localparam logic [1:0] CMD_REBOOT    = 2'h2;
  localparam logic [1:0] CMD_SERVICE   = 2'h3;
  localparam int         IRQ_EXPIRE_BIT = 0;
  localparam logic [31:0] TIMEOUT_RST  = 32'h0000_0001;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ         = 200;
  localparam int SEC_IN_US       = 1000000;
  localparam int CYC_PER_SEC     = CLK_MHZ * SEC_IN_US;
  localparam int RESET_PULSE_NS  = 100;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DEBUG  = 2'b01,
    ST_REBOOT = 2'b11,
    ST_FIRED  = 2'b10
  } wd_state_t;
endpackage

// ==== logic/watchdog_timeout_guard.sv ====
// Watchdog with seconds timeout, debug and reboot expiry, AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
module watchdog_timeout_guard #(
  parameter int unsigned TICK_CYC = wdog_pkg::CYC_PER_SEC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic             irq_out,
  output logic             sys_rst_req_out
);
  // ------------------------------------------------------------
  // Bus address phase capture
  // ------------------------------------------------------------
  logic        wr_pend_r;
  logic [7:0]  addr_r;
  logic [31:0] timeout_r;
  logic [31:0] remain_s_r;
  logic [31:0] tick_cnt_r;
  logic        irq_stat_r;
  logic        irq_en_r;
  logic [7:0]  rst_cnt_r;
  wdog_pkg::wd_state_t state_r;
  logic        addr_ok;
  logic        wr_do;
  logic        cmd_wr;
  logic [1:0]  cmd;
  logic        service;
  logic        running;
  logic        expire;
  logic        sec_tick;
  logic [31:0] rdata_nxt;

  assign addr_ok = hsel_in && hready_in && htrans_in[1];
  assign wr_do   = wr_pend_r;
  assign cmd_wr  = wr_do && addr_r == wdog_pkg::CMD_OFS;
  assign cmd     = hwdata_in[1:0];
  assign running = state_r == wdog_pkg::ST_DEBUG || state_r == wdog_pkg::ST_REBOOT;
  assign service = cmd_wr && cmd == wdog_pkg::CMD_SERVICE && running;
  assign sec_tick = tick_cnt_r == TICK_CYC - 1;
  assign expire  = running && !service && sec_tick && remain_s_r <= 32'h0000_0001;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite_in;
      if (addr_ok) begin
        addr_r <= haddr_in[7:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Timeout register
  // ------------------------------------------------------------
  // whole-second timeout
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timeout_r <= wdog_pkg::TIMEOUT_RST;
    end else if (wr_do && addr_r == wdog_pkg::TIMEOUT_OFS) begin
      timeout_r <= hwdata_in;
    end
  end

  // ------------------------------------------------------------
  // Mode state
  // ------------------------------------------------------------
  // start by command only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= wdog_pkg::ST_IDLE;
    end else if (expire) begin
      state_r <= (state_r == wdog_pkg::ST_REBOOT) ? wdog_pkg::ST_FIRED : wdog_pkg::ST_IDLE;
    end else if (cmd_wr && state_r != wdog_pkg::ST_FIRED) begin
      unique case (cmd)
        wdog_pkg::CMD_STOP:    state_r <= wdog_pkg::ST_IDLE;
        wdog_pkg::CMD_DEBUG:   state_r <= wdog_pkg::ST_DEBUG;
        wdog_pkg::CMD_REBOOT:  state_r <= wdog_pkg::ST_REBOOT;
        wdog_pkg::CMD_SERVICE: state_r <= state_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Countdown
  // ------------------------------------------------------------
  // same counter in both modes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt_r <= 32'h0000_0000;
      remain_s_r <= 32'h0000_0000;
    end else if (cmd_wr && cmd != wdog_pkg::CMD_STOP && (running || cmd != wdog_pkg::CMD_SERVICE)) begin
      tick_cnt_r <= 32'h0000_0000;
      remain_s_r <= timeout_r;
    end else if (running) begin
      if (sec_tick) begin
        tick_cnt_r <= 32'h0000_0000;
        remain_s_r <= (remain_s_r == 32'h0000_0000) ? remain_s_r : remain_s_r - 32'h0000_0001;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt and reset outputs
  // ------------------------------------------------------------
  // debug expiry interrupt
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_r <= 1'b0;
      irq_en_r   <= 1'b0;
      irq_out    <= 1'b0;
    end else begin
      // Set wins over a same-cycle clear
      if (expire && state_r == wdog_pkg::ST_DEBUG) begin
        irq_stat_r <= 1'b1;
      end else if (wr_do && addr_r == wdog_pkg::IRQ_CLR_OFS && hwdata_in[wdog_pkg::IRQ_EXPIRE_BIT]) begin
        irq_stat_r <= 1'b0;
      end
      if (wr_do && addr_r == wdog_pkg::IRQ_EN_OFS) begin
        irq_en_r <= hwdata_in[wdog_pkg::IRQ_EXPIRE_BIT];
      end
      irq_out <= irq_stat_r && irq_en_r;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_cnt_r       <= 8'h00;
      sys_rst_req_out <= 1'b0;
    end else if (expire && state_r == wdog_pkg::ST_REBOOT) begin
      rst_cnt_r       <= 8'(wdog_pkg::RESET_PULSE_CYC);
      sys_rst_req_out <= 1'b1;
    end else if (rst_cnt_r != 8'h00) begin
      rst_cnt_r       <= rst_cnt_r - 8'h01;
      sys_rst_req_out <= 1'b1;
    end else begin
      sys_rst_req_out <= state_r == wdog_pkg::ST_FIRED;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // remaining time readable
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (haddr_in[7:0])
      wdog_pkg::TIMEOUT_OFS:  rdata_nxt = timeout_r;
      wdog_pkg::REMAIN_S_OFS: rdata_nxt = remain_s_r;
      wdog_pkg::REMAIN_T_OFS: rdata_nxt = tick_cnt_r;
      wdog_pkg::STATUS_OFS:   rdata_nxt = {30'h0, state_r};
      wdog_pkg::IRQ_STAT_OFS: rdata_nxt = {31'h0, irq_stat_r};
      wdog_pkg::IRQ_EN_OFS:   rdata_nxt = {31'h0, irq_en_r};
      default:                rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else if (addr_ok && !hwrite_in) begin
      hrdata_out <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // timeout write alone keeps idle
  timeout_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == wdog_pkg::ST_IDLE && !cmd_wr |=> state_r == wdog_pkg::ST_IDLE)
    else $error("watchdog started without command");
  debug_irq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    expire && state_r == wdog_pkg::ST_DEBUG |=> irq_stat_r && !sys_rst_req_out)
    else $error("debug expiry missed interrupt");
  reboot_rst_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    expire && state_r == wdog_pkg::ST_REBOOT |=> sys_rst_req_out)
    else $error("reboot expiry missed reset");
  service_reload_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    service |=> remain_s_r == $past(timeout_r) && tick_cnt_r == 32'h0000_0000)
    else $error("service did not reload");
  count_down_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    running && sec_tick && !cmd_wr && remain_s_r > 32'h0000_0001
      |=> remain_s_r == $past(remain_s_r) - 32'h0000_0001)
    else $error("seconds count wrong");
  timeout_store_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_do && addr_r == wdog_pkg::TIMEOUT_OFS |=> timeout_r == $past(hwdata_in))
    else $error("timeout not stored");
  remain_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    addr_ok && !hwrite_in && haddr_in[7:0] == wdog_pkg::REMAIN_S_OFS
      |=> hrdata_out == $past(remain_s_r))
    else $error("remaining time read wrong");
  irq_level_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_stat_r && irq_en_r |=> irq_out)
    else $error("interrupt output not raised");

  // ------------------------------------------------------------
  // Mode checks
  // ------------------------------------------------------------
  stop_cmd_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_wr && cmd == wdog_pkg::CMD_STOP && state_r != wdog_pkg::ST_FIRED && !expire
      |=> state_r == wdog_pkg::ST_IDLE)
    else $error("stop command ignored");
  start_debug_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_wr && cmd == wdog_pkg::CMD_DEBUG && state_r != wdog_pkg::ST_FIRED && !expire
      |=> state_r == wdog_pkg::ST_DEBUG && remain_s_r == $past(timeout_r))
    else $error("debug start wrong");
  start_reboot_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_wr && cmd == wdog_pkg::CMD_REBOOT && state_r != wdog_pkg::ST_FIRED && !expire
      |=> state_r == wdog_pkg::ST_REBOOT && remain_s_r == $past(timeout_r))
    else $error("reboot start wrong");
  fired_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == wdog_pkg::ST_FIRED |=> state_r == wdog_pkg::ST_FIRED)
    else $error("fired state left before reset");
  fired_rst_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == wdog_pkg::ST_FIRED |-> sys_rst_req_out)
    else $error("fired state without reset request");
  debug_no_rst_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state_r == wdog_pkg::ST_DEBUG |-> !sys_rst_req_out)
    else $error("reset request in debug mode");
  debug_to_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    expire && state_r == wdog_pkg::ST_DEBUG |=> state_r == wdog_pkg::ST_IDLE)
    else $error("debug expiry kept counting");

  // ------------------------------------------------------------
  // Counter checks
  // ------------------------------------------------------------
  idle_frozen_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !running && !cmd_wr |=> $stable(remain_s_r) && $stable(tick_cnt_r))
    else $error("counter moved while stopped");
  tick_wrap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    running && sec_tick && !cmd_wr |=> tick_cnt_r == 32'h0000_0000)
    else $error("second counter did not wrap");
  tick_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    running && !sec_tick && !cmd_wr |=> tick_cnt_r == $past(tick_cnt_r) + 32'h0000_0001)
    else $error("second counter did not step");
  tick_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    tick_cnt_r < TICK_CYC)
    else $error("second counter out of range");
  remain_mono_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    running && !cmd_wr |=> remain_s_r <= $past(remain_s_r))
    else $error("remaining time rose without command");
  service_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmd_wr && cmd == wdog_pkg::CMD_SERVICE && !running |=> $stable(remain_s_r))
    else $error("service while stopped reloaded");
  timeout_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(wr_do && addr_r == wdog_pkg::TIMEOUT_OFS) |=> $stable(timeout_r))
    else $error("timeout changed without write");

  // ------------------------------------------------------------
  // Interrupt and bus checks
  // ------------------------------------------------------------
  irq_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_do && addr_r == wdog_pkg::IRQ_CLR_OFS && hwdata_in[wdog_pkg::IRQ_EXPIRE_BIT]
      && !(expire && state_r == wdog_pkg::ST_DEBUG) |=> !irq_stat_r)
    else $error("interrupt clear ignored");
  irq_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(irq_stat_r && irq_en_r) |=> !irq_out)
    else $error("interrupt output stuck high");
  hrdata_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(addr_ok && !hwrite_in) |=> $stable(hrdata_out))
    else $error("read data moved without read");
  remain_tick_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    addr_ok && !hwrite_in && haddr_in[7:0] == wdog_pkg::REMAIN_T_OFS
      |=> hrdata_out == $past(tick_cnt_r))
    else $error("elapsed cycles read wrong");

  // ------------------------------------------------------------
  // Expiry sequences
  // ------------------------------------------------------------
  sequence debug_expiry_s;
    expire && state_r == wdog_pkg::ST_DEBUG;
  endsequence
  sequence reboot_expiry_s;
    expire && state_r == wdog_pkg::ST_REBOOT;
  endsequence
  // Request must outlast any pulse stretcher on the chip reset
  sequence reset_held_s;
    sys_rst_req_out [*8];
  endsequence
  debug_irq_pin_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    debug_expiry_s ##1 irq_en_r |=> irq_out)
    else $error("debug expiry interrupt pin low");
  reboot_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reboot_expiry_s |=> reset_held_s)
    else $error("reboot reset request not held");
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the watchdog timeout guard
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic hready_in = 1'b1;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, got;
  logic [1:0] htrans_in = 2'h0;
  logic [2:0] hsize_in = 3'h2;
  logic hreadyout_out, hresp_out, irq_out, sys_rst_req_out;
  logic [7:0] rnd = 8'h0E;
  logic [31:0] tmo;
  int n_fail = 0, total_checks = 0;
  string qn[$];
  logic [31:0] qv[$];
  event got_e;
  // Short second so a run stays a few hundred cycles
  watchdog_timeout_guard #(.TICK_CYC(10)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .irq_out(irq_out), .sys_rst_req_out(sys_rst_req_out));
  always #2.5 clk_in = ~clk_in;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // ------------------------------------------------------------
  // Scoreboard: oldest note against each result
  // ------------------------------------------------------------
  always @(got_e) begin
    total_checks++;
    if (qv.size() == 0) begin
      n_fail++;
      $display("BAD unexpected result seen %h", got);
    end else begin
      if (got !== qv[0]) begin
        n_fail++;
        $display("BAD %s expected %h seen %h", qn[0], qv[0], got);
      end
      void'(qn.pop_front());
      void'(qv.pop_front());
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hold_ready();
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (hreadyout_out !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    hold_ready();
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    hold_ready();
    r = hrdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    qn.push_back(n);
    qv.push_back(e);
    xfer(1'b0, a, 32'h0, r);
    got = r;
    ->got_e;
  endtask
  task automatic sig(input string n, input logic e);
    // Registered outputs follow their cause by one edge
    @(posedge clk_in);
    #1;
    qn.push_back(n);
    qv.push_back({31'h0, e});
    got = {31'h0, (n == "irq") ? irq_out : ((n == "rst") ? sys_rst_req_out : hresp_out)};
    ->got_e;
  endtask
  task automatic wait_hi(input logic s, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge clk_in);
      if ((s ? sys_rst_req_out : irq_out) === 1'b1) break;
    end
    if (k >= lim) begin
      n_fail++;
      stop_test();
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd("timeout", wdog_pkg::TIMEOUT_OFS, wdog_pkg::TIMEOUT_RST);
    rd("state", wdog_pkg::STATUS_OFS, 32'h0);
    rd("irq_en", wdog_pkg::IRQ_EN_OFS, 32'h0);
    rd("unmapped", 8'h20, 32'h0);
    sig("hresp", 1'b0);
    wr(wdog_pkg::TIMEOUT_OFS, 32'h3);
    repeat (60) @(posedge clk_in);
    rd("state", wdog_pkg::STATUS_OFS, 32'h0);
    rd("irq_stat", wdog_pkg::IRQ_STAT_OFS, 32'h0);
    rd("remain", wdog_pkg::REMAIN_S_OFS, 32'h0);
    $display("test reset and idle done");
    rnd = lfsr(rnd);
    wr(wdog_pkg::IRQ_EN_OFS, {31'h0, 1'b1});
    wr(wdog_pkg::CMD_OFS, {30'h0, wdog_pkg::CMD_DEBUG});
    rd("remain", wdog_pkg::REMAIN_S_OFS, 32'h3);
    rd("state", wdog_pkg::STATUS_OFS, 32'h1);
    rd("ticks", wdog_pkg::REMAIN_T_OFS, 32'h4);
    repeat (8) @(posedge clk_in);
    rd("remain", wdog_pkg::REMAIN_S_OFS, 32'h2);
    wait_hi(1'b0, 40);
    sig("irq", 1'b1);
    sig("rst", 1'b0);
    rd("state", wdog_pkg::STATUS_OFS, 32'h0);
    wr(wdog_pkg::IRQ_EN_OFS, 32'h0);
    sig("irq", 1'b0);
    rd("irq_stat", wdog_pkg::IRQ_STAT_OFS, 32'h1);
    wr(wdog_pkg::IRQ_EN_OFS, 32'h1);
    sig("irq", 1'b1);
    wr(wdog_pkg::IRQ_CLR_OFS, 32'h1);
    sig("irq", 1'b0);
    rd("irq_stat", wdog_pkg::IRQ_STAT_OFS, 32'h0);
    $display("test debug expiry done");
    // Random timeout of two or three seconds
    tmo = {30'h0, 1'b1, rnd[0]};
    wr(wdog_pkg::TIMEOUT_OFS, tmo);
    wr(wdog_pkg::CMD_OFS, {30'h0, wdog_pkg::CMD_DEBUG});
    repeat (5) begin
      repeat (9) @(posedge clk_in);
      wr(wdog_pkg::CMD_OFS, {30'h0, wdog_pkg::CMD_SERVICE});
      rd("remain", wdog_pkg::REMAIN_S_OFS, tmo);
    end
    rd("irq_stat", wdog_pkg::IRQ_STAT_OFS, 32'h0);
    wr(wdog_pkg::CMD_OFS, {30'h0, wdog_pkg::CMD_STOP});
    rd("state", wdog_pkg::STATUS_OFS, 32'h0);
    $display("test service done");
    wr(wdog_pkg::CMD_OFS, {30'h0, wdog_pkg::CMD_REBOOT});
    rd("state", wdog_pkg::STATUS_OFS, 32'h3);
    wait_hi(1'b1, 60);
    sig("rst", 1'b1);
    wr(wdog_pkg::CMD_OFS, {30'h0, wdog_pkg::CMD_DEBUG});
    rd("state", wdog_pkg::STATUS_OFS, 32'h2);
    sig("irq", 1'b0);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    sig("rst", 1'b0);
    $display("test reboot expiry done");
    stop_test();
  end
endmodule
`default_nettype wire
